// [src/psa_pkg.sv]
package psa_pkg;

  localparam int unsigned PSA_LANES      = 4;
  localparam int unsigned PSA_LANE_W     = 9;
  localparam int unsigned PSA_ADDR_W     = 19;
  localparam int unsigned PSA_BURST_W    = 2;
  localparam int unsigned PSA_BURST_LSB  = 0;

  localparam logic       PSA_ORDER_LINEAR = 1'b0;
  localparam logic [1:0] PSA_BEAT_FIRST   = 2'h0;
  localparam logic [1:0] PSA_BEAT_STEP    = 2'h1;
  localparam logic       PSA_OE_RESET     = 1'b0;

endpackage

// [src/psa_sram_core.sv]
`timescale 1ns/1ps

// Contract
// - Inputs are sampled on the rising edge; read data is registered.
// - Burst order comes from sampling the order-select input.
// - A two-bit wrapping burst counter loads from the low address bits.
// - Burst step low at a clock rise advances the counter, reads and writes.
// - Global write low writes all four lanes, ignoring selects and gate.
// - Byte-write gate with lane selects writes only the selected lanes.
// - A strobe with all selects active and no write controls starts a read.
// - A started access loads the address register and burst logic.
// - Read data drives one rise after capture while output enable is low.
// - Outputs stay tri-stated in the first cycle after leaving deselect.
// - A strobe with inactive chip selects tri-states the outputs at once, unless it is a processor strobe with primary select high.
// - Processor-strobe writes ignore write controls and step in cycle one.
// - Processor-strobe writes take two cycles; data commits at the second.
// - At that rise global write writes all lanes, else gate and selects.
// - Data drivers are off whenever a write cycle is detected.
// - A controller-strobe write needs processor strobe high, selects, write.
// - Controller-strobe writes finish in one cycle, all or selected lanes.
// - Burst step is ignored in the controller-strobe write cycle.
// - With both strobes low and primary select low only the processor strobe is acted upon.
// - Order select low means linear, high means interleaved.
// - Chip selects are sampled only when a new address is loaded.
module psa_sram_core
  import psa_pkg::*;
#(
  parameter int unsigned ADDR_W = PSA_ADDR_W,
  parameter int unsigned LANES  = PSA_LANES,
  parameter int unsigned LANE_W = PSA_LANE_W
) (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_i,
  input  wire logic [ADDR_W-1:0]         addr_i,
  input  wire logic                      processor_addr_strobe_n_i,
  input  wire logic                      controller_addr_strobe_n_i,
  input  wire logic                      burst_step_n_i,
  input  wire logic                      global_write_n_i,
  input  wire logic                      byte_write_gate_n_i,
  input  wire logic [LANES-1:0]          byte_lane_write_n_i,
  input  wire logic                      chip_sel_primary_n_i,
  input  wire logic                      chip_sel_depth_hi_i,
  input  wire logic                      chip_sel_depth_lo_n_i,
  input  wire logic                      output_enable_n_i,
  input  wire logic                      burst_order_sel_i,
  input  wire logic [LANES*LANE_W-1:0]   dq_i,
  output logic      [LANES*LANE_W-1:0]   dq_o,
  output logic                           dq_oe_o
);

  localparam int unsigned DATA_W = LANES * LANE_W;
  localparam int unsigned DEPTH  = 2 ** ADDR_W;
  localparam int unsigned HI_LSB = PSA_BURST_LSB + PSA_BURST_W;

  typedef struct packed {
    logic                 selected;
    logic                 reading;
    logic                 order_il;
    logic [ADDR_W-1:0]    addr;
    logic [1:0]           start;
    logic [1:0]           beat;
    logic [DATA_W-1:0]    dq;
    logic                 dq_oe;
  } psa_state_s;

  psa_state_s             st;
  psa_state_s             next_st;

  logic                   proc_take;
  logic                   ctrl_take;
  logic                   all_sel;
  logic                   wr_req;
  logic                   wr_now;
  logic                   desel_now;
  logic [LANES-1:0]       req_lanes;
  logic [LANES-1:0]       wr_lanes;
  logic [ADDR_W-1:0]      cur_addr;
  logic [ADDR_W-1:0]      wr_addr;
  logic [DATA_W-1:0]      rd_word;

  function automatic logic [1:0] psa_burst_low(input logic [1:0] start,
                                               input logic [1:0] beat,
                                               input logic       il);
    logic [1:0] res;
    if (il) begin
      res = start ^ beat;
    end else begin
      res = 2'(start + beat);
    end
    return res;
  endfunction

  // Processor strobe is dropped when the primary select is high; with both
  // strobes low the processor strobe wins.
  assign proc_take = !processor_addr_strobe_n_i
                     && !chip_sel_primary_n_i;
  assign ctrl_take = !controller_addr_strobe_n_i
                     && !proc_take;
  assign all_sel   = !chip_sel_primary_n_i && chip_sel_depth_hi_i
                     && !chip_sel_depth_lo_n_i;

  // Global write overrides the gate and the lane selects.
  always_comb begin
    if (!global_write_n_i) begin
      req_lanes = '1;
    end else if (!byte_write_gate_n_i) begin
      req_lanes = ~byte_lane_write_n_i;
    end else begin
      req_lanes = '0;
    end
  end

  assign wr_req   = |req_lanes;
  assign cur_addr = {st.addr[ADDR_W-1:HI_LSB],
                     psa_burst_low(st.start, st.beat, st.order_il)};

  always_comb begin
    next_st   = st;
    wr_now    = 1'b0;
    desel_now = 1'b0;
    if (proc_take || ctrl_take) begin
      next_st.addr     = addr_i;
      next_st.start    = addr_i[HI_LSB-1:PSA_BURST_LSB];
      next_st.beat     = PSA_BEAT_FIRST;
      next_st.order_il = burst_order_sel_i != PSA_ORDER_LINEAR;
      next_st.selected = all_sel;
      if (!all_sel) begin
        desel_now       = 1'b1;
        next_st.reading = 1'b0;
      end else if (ctrl_take && wr_req) begin
        wr_now          = 1'b1;
        next_st.reading = 1'b0;
      end else begin
        // A processor strobe always opens as a read; writes come later.
        next_st.reading = 1'b1;
      end
    end else if (st.selected) begin
      if (!burst_step_n_i) begin
        next_st.beat = 2'(st.beat + PSA_BEAT_STEP);
      end
      wr_now          = wr_req;
      next_st.reading = !wr_req;
    end
    if (st.reading) begin
      next_st.dq = rd_word;
    end
    // Enable follows the held read only; a fresh select leaves it off.
    next_st.dq_oe = st.reading && !output_enable_n_i
                    && !wr_now && !desel_now;
  end

  assign wr_addr  = {next_st.addr[ADDR_W-1:HI_LSB],
                     psa_burst_low(next_st.start, next_st.beat,
                                   next_st.order_il)};
  assign wr_lanes = wr_now ? req_lanes : '0;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st          <= '0;
      st.start    <= PSA_BEAT_FIRST;
      st.beat     <= PSA_BEAT_FIRST;
      st.dq_oe    <= PSA_OE_RESET;
    end else begin
      st <= next_st;
    end
  end

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [LANE_W-1:0] lane_mem [DEPTH];
      always_ff @(posedge sys_clk_i) begin
        if (wr_lanes[g]) begin
          lane_mem[wr_addr] <= dq_i[g*LANE_W +: LANE_W];
        end
      end
      assign rd_word[g*LANE_W +: LANE_W] = lane_mem[cur_addr];
    end
  endgenerate

  assign dq_o    = st.dq;
  assign dq_oe_o = st.dq_oe;

  default clocking psa_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  a_desel_tristate: assert property (
    (proc_take || ctrl_take) && !all_sel |=> !dq_oe_o && !st.selected)
    else $error("outputs not tri-stated after deselect");

  a_first_cycle_off: assert property (
    !st.selected && proc_take && all_sel |=> !dq_oe_o)
    else $error("outputs enabled in first cycle after select");

  a_write_tristate: assert property (
    wr_now |=> !dq_oe_o)
    else $error("outputs enabled during a write");

  a_read_pipe: assert property (
    proc_take && all_sel ##1 (!output_enable_n_i && !wr_now
      && !proc_take && !ctrl_take) |=> dq_oe_o
      && dq_o == $past(rd_word))
    else $error("read data not driven one cycle after capture");

  a_burst_advance: assert property (
    st.selected && !proc_take && !ctrl_take && !burst_step_n_i
    |=> st.beat == 2'($past(st.beat) + PSA_BEAT_STEP))
    else $error("burst counter did not advance");

  a_burst_hold: assert property (
    !proc_take && !ctrl_take && burst_step_n_i |=> $stable(st.beat))
    else $error("burst counter moved without a step");

  a_addr_load: assert property (
    proc_take || ctrl_take |=> st.beat == PSA_BEAT_FIRST
      && st.start == $past(addr_i[HI_LSB-1:PSA_BURST_LSB])
      && st.addr == $past(addr_i))
    else $error("address or burst counter not loaded");

  a_proc_ignored: assert property (
    chip_sel_primary_n_i && controller_addr_strobe_n_i |=> $stable(st.addr))
    else $error("processor strobe acted with primary select high");

  a_proc_first: assert property (
    proc_take |-> wr_lanes == '0)
    else $error("write in first cycle of processor strobe");

  a_ctrl_write: assert property (
    ctrl_take && all_sel && wr_req |-> wr_lanes == req_lanes
      && wr_addr == addr_i)
    else $error("controller strobe write not committed at once");

  a_global_all: assert property (
    wr_now && !global_write_n_i |-> &wr_lanes)
    else $error("global write did not cover all lanes");

  a_burst_order: assert property (
    st.order_il |-> cur_addr[HI_LSB-1:PSA_BURST_LSB] == (st.start ^ st.beat))
    else $error("interleaved burst address wrong");

  a_linear_order: assert property (
    !st.order_il |-> cur_addr[HI_LSB-1:PSA_BURST_LSB]
      == 2'(st.start + st.beat))
    else $error("linear burst address wrong");

  // The order is latched per access, so a change between accesses is safe.
  a_order_sample: assert property (
    proc_take || ctrl_take |=> st.order_il
      == ($past(burst_order_sel_i) != PSA_ORDER_LINEAR))
    else $error("burst order not sampled at access start");

  a_sel_sample: assert property (
    proc_take || ctrl_take
    |=> st.selected == $past(all_sel))
    else $error("chip selects not sampled on a strobe");

  // Between strobes the selects may wander freely without effect.
  a_sel_hold: assert property (
    !proc_take && !ctrl_take
    |=> $stable(st.selected))
    else $error("selection changed without a strobe");

  a_proc_wins: assert property (
    !processor_addr_strobe_n_i && !chip_sel_primary_n_i
    |-> proc_take && !ctrl_take)
    else $error("controller strobe acted beside processor strobe");

  a_ctrl_no_step: assert property (
    ctrl_take && all_sel && wr_req
    |=> st.beat == PSA_BEAT_FIRST)
    else $error("burst step acted in controller write cycle");

  a_byte_lanes: assert property (
    wr_now && global_write_n_i
    |-> wr_lanes == ~byte_lane_write_n_i)
    else $error("byte write touched unselected lanes");

  a_idle_no_write: assert property (
    !st.selected && !proc_take && !ctrl_take
    |-> wr_lanes == '0)
    else $error("write while deselected");

  a_dq_load: assert property (
    st.reading
    |=> dq_o == $past(rd_word))
    else $error("output register not loaded on a read");

  a_dq_hold: assert property (
    !st.reading
    |=> $stable(dq_o))
    else $error("output register moved without a read");

  // Output enable is sampled, so it acts one edge late on the drivers.
  a_oe_gate: assert property (
    output_enable_n_i
    |=> !dq_oe_o)
    else $error("outputs driven with output enable high");

  a_proc_commit: assert property (
    st.selected && !proc_take && !ctrl_take && wr_req
    |-> wr_lanes == req_lanes)
    else $error("second-cycle write not committed");

  a_ctrl_done: assert property (
    ctrl_take && all_sel && wr_req
    |=> !st.reading)
    else $error("controller write did not finish in one cycle");

  a_read_open: assert property (
    proc_take && all_sel
    |=> st.reading)
    else $error("processor strobe did not open a read");

  a_desel_idle: assert property (
    !st.selected && !proc_take && !ctrl_take
    |=> !dq_oe_o)
    else $error("outputs driven while deselected");

  a_proc_addr: assert property (
    proc_take && all_sel
    |=> cur_addr == $past(addr_i))
    else $error("captured address not applied to the array");

  a_proc_no_step: assert property (
    proc_take
    |=> st.beat == PSA_BEAT_FIRST)
    else $error("burst step acted in processor strobe cycle");

  // Without a step a continuation write lands on the current address.
  a_wr_addr_cur: assert property (
    st.selected && !proc_take && !ctrl_take && burst_step_n_i
    |-> wr_addr == cur_addr)
    else $error("continuation write at wrong address");

  a_read_cont: assert property (
    st.selected && st.reading && !proc_take && !ctrl_take && !wr_req
      && !output_enable_n_i
    |=> dq_oe_o)
    else $error("read continuation not driven");

  a_no_take_prim: assert property (
    chip_sel_primary_n_i && controller_addr_strobe_n_i
    |-> !proc_take && !ctrl_take)
    else $error("access taken with primary select high");

endmodule

// [tb/psa_ctrl_model.sv]
`timescale 1ns/1ps
module psa_ctrl_model
  import psa_pkg::*;
#(
  parameter int unsigned ADDR_W = PSA_ADDR_W
) (
  input  wire logic              sys_clk_i,
  output logic      [ADDR_W-1:0] addr_o,
  output logic      [4:0]        ctl_n_o,
  output logic      [3:0]        lane_n_o,
  output logic      [2:0]        sel_o,
  output logic                   oe_n_o,
  output logic      [35:0]       dq_o
);
  initial begin
    addr_o   = '0;
    ctl_n_o  = 5'h1F;
    lane_n_o = 4'hF;
    sel_o    = 3'h0;
    oe_n_o   = 1'b1;
    dq_o     = '0;
  end
  // Control bits are {proc, ctrl, step, global, gate}, all active low.
  task automatic drive(input logic [4:0] k, input logic [3:0] l,
                       input logic [2:0] s, input logic [ADDR_W-1:0] a,
                       input logic [35:0] d, input logic oe);
    logic wr;
    wr = !k[1] || (!k[0] && l != 4'hF);
    @(posedge sys_clk_i);
    ctl_n_o  <= k;
    lane_n_o <= l;
    sel_o    <= s;
    addr_o   <= a;
    oe_n_o   <= oe || wr;
    dq_o     <= wr ? d : ~dq_o;
  endtask
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
  import psa_pkg::*;
  localparam int unsigned AW = 6;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic          il  = 1'b1;
  logic [AW-1:0] addr;
  logic [4:0]    ctl;
  logic [3:0]    lane;
  logic [2:0]    sel;
  logic          oe_n;
  logic [35:0]   dq_w;
  logic [35:0]   dq_r;
  logic [35:0]   dq_bus;
  logic          dq_oe;
  logic [35:0]   mem [64];
  int            error_cnt = 0;
  int            n_compared = 0;
  int            cycles = 0;
  assign dq_bus = dq_oe ? dq_r : dq_w;
  psa_ctrl_model #(.ADDR_W(AW)) i_ctrl (.sys_clk_i(clk), .addr_o(addr),
    .ctl_n_o(ctl), .lane_n_o(lane), .sel_o(sel), .oe_n_o(oe_n), .dq_o(dq_w));
  psa_sram_core #(.ADDR_W(AW)) i_dut (.sys_clk_i(clk), .rst_i(rst),
    .addr_i(addr), .processor_addr_strobe_n_i(ctl[4]),
    .controller_addr_strobe_n_i(ctl[3]), .burst_step_n_i(ctl[2]),
    .global_write_n_i(ctl[1]), .byte_write_gate_n_i(ctl[0]),
    .byte_lane_write_n_i(lane), .chip_sel_primary_n_i(sel[2]),
    .chip_sel_depth_hi_i(sel[1]), .chip_sel_depth_lo_n_i(sel[0]),
    .output_enable_n_i(oe_n), .burst_order_sel_i(il), .dq_i(dq_bus),
    .dq_o(dq_r), .dq_oe_o(dq_oe));
  initial begin
    forever #5 clk = ~clk;
  end
  function automatic logic [35:0] rnd();
    rnd = 36'({$urandom(), $urandom()});
  endfunction
  function automatic logic [AW-1:0] ba(input logic [AW-1:0] a,
                                       input logic [1:0] j, input logic o);
    ba = {a[AW-1:2], o ? a[1:0] ^ j : a[1:0] + j};
  endfunction
  function automatic logic [35:0] merge(input logic [35:0] old,
                                        input logic [35:0] d,
                                        input logic [3:0] l);
    merge = old;
    for (int k = 0; k < 4; k++) begin
      if (!l[k]) merge[9*k+:9] = d[9*k+:9];
    end
  endfunction
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Starts from deselect, reads five beats, then deselects again.
  task automatic burst(input logic [AW-1:0] a);
    i_ctrl.drive(5'h0B, 4'hF, 3'h2, a, '0, 1'b0);
    #1 chk({35'h0, dq_oe}, 36'h0);
    i_ctrl.drive(5'h1B, 4'hF, 3'($urandom), a, '0, 1'b0);
    #1 chk({35'h0, dq_oe}, 36'h0);
    for (int j = 0; j < 5; j++) begin
      i_ctrl.drive(5'h1B, 4'hF, 3'($urandom), a, '0, 1'b0);
      #1 chk(dq_r, mem[ba(a, 2'(j), il)]);
      chk({35'h0, dq_oe}, 36'h1);
    end
    i_ctrl.drive(5'h17, 4'hF, 3'h2 ^ (3'h1 << ($urandom % 3)), a, '0, 1'b0);
  endtask
  initial begin
    logic [35:0]   d;
    logic [3:0]    l;
    logic [AW-1:0] a;
    logic          g;
    void'($urandom(32'hD2D9));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 64; i++) begin
      d = rnd();
      i_ctrl.drive(5'h15, 4'hF, 3'h2, 6'(i), d, 1'b1);
      mem[i] = d;
    end
    for (int i = 0; i < 24; i++) begin
      d = rnd();
      a = 6'($urandom);
      l = 4'($urandom);
      g = 1'($urandom);
      i_ctrl.drive({3'h4, g, 1'b0}, l, 3'h2, a, d, 1'b1);
      mem[a] = merge(mem[a], d, g ? l : 4'h0);
    end
    i_ctrl.drive(5'h0F, 4'hF, 3'h2, 6'h0, '0, 1'b0);
    i_ctrl.drive(5'h0F, 4'hF, 3'h6, 6'h0, '0, 1'b0);
    repeat (2) i_ctrl.drive(5'h1F, 4'hF, 3'h2, 6'h0, '0, 1'b0);
    #1 chk({35'h0, dq_oe}, 36'h1);
    for (int i = 0; i < 8; i++) begin
      d = rnd();
      a = 6'($urandom);
      l = 4'($urandom);
      g = 1'($urandom);
      i_ctrl.drive({1'b0, 1'($urandom), 3'h0}, 4'h0, 3'h2, a, rnd(), 1'b0);
      i_ctrl.drive({3'h7, g, 1'b0}, l, 3'($urandom), a, d, 1'b0);
      mem[a] = merge(mem[a], d, g ? l : 4'h0);
      i_ctrl.drive(5'h1F, 4'hF, 3'h2, a, '0, 1'b0);
      #1 chk({35'h0, dq_oe}, {35'h0, g && l == 4'hF});
    end
    i_ctrl.drive(5'h17, 4'hF, 3'h0, 6'h0, '0, 1'b0);
    for (int n = 0; n < 16; n++) begin
      il <= n[0];
      burst(6'($urandom));
    end
    finish_test();
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      finish_test();
    end
  end
endmodule
